// ===== pft_top.sv
/*
  Port overload fault timer for a multi-channel power sourcing
  controller: APB register file, pin synchronisers, power status and
  one overload timer per channel on a shared time base.
  Assumes an APB master on the same clock, analog comparator levels on
  overCurrent, currentLimiting and powerGoodIn, and same-clock pulses
  on the fault, disconnect and power-on inputs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pft_cfg.svh"

module pft_top #(
  parameter int NCH = 8,
  parameter int CW = 10,
  parameter int TICK_CYCLES = `PFT_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] overCurrent,
  input wire logic [NCH-1:0] currentLimiting,
  input wire logic [NCH-1:0] powerGoodIn,
  input wire logic [NCH-1:0] dcDisconnect,
  input wire logic [NCH-1:0] currentLimitFault,
  input wire logic [NCH-1:0] startFault,
  input wire logic [NCH-1:0] powerOnRequest,
  output logic [NCH-1:0] channelPowerEnable,
  output logic [NCH-1:0] channelPowerGood,
  output logic [NCH-1:0] detectStart,
  output logic [1:0] overloadTimeSelect,
  output logic [1:0] disconnectDelaySelect
);
  import pft_pkg::*;

  if (NCH < 1 || NCH > 8)
  begin : gBadNch
    $error("pft_top: NCH must be 1 to 8");
  end
  if ((1 << CW) <= `PFT_COOL_MS)
  begin : gBadCw
    $error("pft_top: CW too narrow");
  end

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdata,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = wdata[8*i +: 8];
    return r;
  endfunction

  function automatic logic [CW-1:0] ovldTicks(input logic [1:0] sel);
    logic [CW-1:0] r;
    case (sel)
      2'h0: r = CW'(`PFT_OVLD_MS_00);
      2'h1: r = CW'(`PFT_OVLD_MS_01);
      2'h2: r = CW'(`PFT_OVLD_MS_10);
      2'h3: r = CW'(`PFT_OVLD_MS_11);
      default: r = CW'(`PFT_OVLD_MS_00);
    endcase
    return r;
  endfunction

  // pin synchronisers
  logic [NCH-1:0] overMeta;
  logic [NCH-1:0] overSync;
  logic [NCH-1:0] limMeta;
  logic [NCH-1:0] limSync;
  logic [NCH-1:0] pgMeta;
  logic [NCH-1:0] pgSync;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      overMeta <= '0;
      overSync <= '0;
      limMeta <= '0;
      limSync <= '0;
      pgMeta <= '0;
      pgSync <= '0;
    end
    else
    begin
      overMeta <= overCurrent;
      overSync <= overMeta;
      limMeta <= currentLimiting;
      limSync <= limMeta;
      pgMeta <= powerGoodIn;
      pgSync <= pgMeta;
    end
  end

  // register file state
  logic [3:0] timing;
  logic [NCH-1:0] semiauto;
  logic [NCH-1:0] manual;
  logic [NCH-1:0] detectEn;
  logic [NCH-1:0] pcutDis;
  logic [NCH-1:0] resetCmd;
  logic [NCH-1:0] offCmd;
  logic [NCH-1:0] faultSticky;
  logic ovldChange;
  logic [3:0] next_timing;
  logic [NCH-1:0] next_semiauto;
  logic [NCH-1:0] next_manual;
  logic [NCH-1:0] next_detectEn;
  logic [NCH-1:0] next_pcutDis;
  logic [NCH-1:0] next_resetCmd;
  logic [NCH-1:0] next_offCmd;
  logic [NCH-1:0] next_faultSticky;
  logic next_ovldChange;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic [NCH-1:0] enable;
  logic [NCH-1:0] next_enable;
  logic [NCH-1:0] next_good;
  logic [NCH-1:0] next_detect;
  logic [NCH-1:0] timeoutEv;
  logic [NCH-1:0] turnOff;
  logic [NCH-1:0] detectEv;
  logic [NCH-1:0] cooling;
  logic tick;
  logic leakTick;

  logic access;
  logic done;
  logic [31:0] readWord;
  logic mapped;
  logic [31:0] w;

  assign access = psel & penable;
  assign done = access & pready;

  always_comb
  begin
    readWord = '0;
    mapped = 1'b1;
    case (paddr)
      `PFT_ADDR_TIMING: readWord[3:0] = timing;
      `PFT_ADDR_MODE:
      begin
        readWord[NCH-1:0] = semiauto;
        readWord[`PFT_HI_LSB +: NCH] = manual;
      end
      `PFT_ADDR_DETECT: readWord[NCH-1:0] = detectEn;
      `PFT_ADDR_PCUTDIS: readWord[NCH-1:0] = pcutDis;
      `PFT_ADDR_COMMAND: readWord = '0;
      `PFT_ADDR_STATUS:
      begin
        readWord[NCH-1:0] = enable;
        readWord[`PFT_HI_LSB +: NCH] = channelPowerGood;
        readWord[`PFT_COOL_LSB +: NCH] = cooling;
      end
      `PFT_ADDR_FAULT: readWord[NCH-1:0] = faultSticky;
      default: mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    next_timing = timing;
    next_semiauto = semiauto;
    next_manual = manual;
    next_detectEn = detectEn;
    next_pcutDis = pcutDis;
    next_resetCmd = '0;
    next_offCmd = '0;
    next_faultSticky = faultSticky;
    next_ovldChange = 1'b0;
    next_pready = access & ~pready;
    next_prdata = '0;
    next_pslverr = 1'b0;
    w = '0;
    if (access && !pready)
    begin
      next_prdata = pwrite ? 32'h0000_0000 : readWord;
      next_pslverr = ~mapped;
    end
    if (done && pwrite)
    begin
      case (paddr)
        `PFT_ADDR_TIMING:
        begin
          w = merge({28'h000_0000, timing}, pwdata, pstrb);
          next_timing = w[3:0];
          next_ovldChange = (w[3:2] != timing[3:2]);
        end
        `PFT_ADDR_MODE:
        begin
          w = merge(32'h0000_0000, pwdata, pstrb);
          w[NCH-1:0] = pstrb[0] ? w[NCH-1:0] : semiauto;
          w[`PFT_HI_LSB +: NCH] = pstrb[1] ? w[`PFT_HI_LSB +: NCH] : manual;
          next_semiauto = w[NCH-1:0];
          next_manual = w[`PFT_HI_LSB +: NCH];
        end
        `PFT_ADDR_DETECT:
        begin
          w = merge({{(32-NCH){1'b0}}, detectEn}, pwdata, pstrb);
          next_detectEn = w[NCH-1:0];
        end
        `PFT_ADDR_PCUTDIS:
        begin
          w = merge({{(32-NCH){1'b0}}, pcutDis}, pwdata, pstrb);
          next_pcutDis = w[NCH-1:0];
        end
        `PFT_ADDR_COMMAND:
        begin
          w = merge(32'h0000_0000, pwdata, pstrb);
          next_resetCmd = w[NCH-1:0];
          next_offCmd = w[`PFT_HI_LSB +: NCH];
        end
        `PFT_ADDR_FAULT:
        begin
          w = merge(32'h0000_0000, pwdata, pstrb);
          next_faultSticky = faultSticky & ~w[NCH-1:0];
        end
        default: w = '0;
      endcase
    end
    // a new timeout event beats a clear in the same cycle
    next_faultSticky = next_faultSticky | timeoutEv;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      timing <= `PFT_TIMING_RESET;
      semiauto <= '0;
      manual <= '0;
      detectEn <= '0;
      pcutDis <= '0;
      resetCmd <= '0;
      offCmd <= '0;
      faultSticky <= '0;
      ovldChange <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      timing <= next_timing;
      semiauto <= next_semiauto;
      manual <= next_manual;
      detectEn <= next_detectEn;
      pcutDis <= next_pcutDis;
      resetCmd <= next_resetCmd;
      offCmd <= next_offCmd;
      faultSticky <= next_faultSticky;
      ovldChange <= next_ovldChange;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // power status: a fault or disconnect pin, a timer turn-off or a reset/off command wins over a power-on request
  always_comb
  begin
    next_enable = (enable | powerOnRequest) &
                  ~(currentLimitFault | startFault | dcDisconnect |
                    turnOff | resetCmd | offCmd);
    next_good = next_enable & pgSync;
    next_detect = detectEv;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      enable <= '0;
      channelPowerEnable <= '0;
      channelPowerGood <= '0;
      detectStart <= '0;
      overloadTimeSelect <= '0;
      disconnectDelaySelect <= '0;
    end
    else
    begin
      enable <= next_enable;
      channelPowerEnable <= next_enable;
      channelPowerGood <= next_good;
      detectStart <= next_detect;
      overloadTimeSelect <= next_timing[`PFT_OVLD_LSB +: 2];
      disconnectDelaySelect <= next_timing[`PFT_MPDO_LSB +: 2];
    end
  end

  pft_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) timeBase (
    .clock(clock),
    .resetn(resetn),
    .tick(tick),
    .leakTick(leakTick)
  );

  for (genvar c = 0; c < NCH; c++)
  begin : gChan
    pft_chin_t cin;
    pft_chout_t cout;
    assign cin.over = (overSync[c] | limSync[c]) & enable[c];
    assign cin.clear = resetCmd[c] | offCmd[c] | dcDisconnect[c] |
                       ovldChange;
    assign cin.abort = resetCmd[c] | offCmd[c] | manual[c];
    assign cin.pcutDis = pcutDis[c];
    assign cin.autoDetect = semiauto[c] & ~manual[c] & detectEn[c];
    assign timeoutEv[c] = cout.timeout;
    assign turnOff[c] = cout.turnOff;
    assign detectEv[c] = cout.detect;
    assign cooling[c] = cout.cooling;
    pft_channel #(
      .CW(CW)
    ) chan (
      .clock(clock),
      .resetn(resetn),
      .tick(tick),
      .leakTick(leakTick),
      .limit(ovldTicks(timing[`PFT_OVLD_LSB +: 2])),
      .cin(cin),
      .cout(cout)
    );
  end

endmodule

`default_nettype wire

// ===== pft_cfg.svh
/*
  Address map, field positions, reset values and timing figures of the
  port overload fault timer.
  Assumes a 100 MHz clock and byte addresses on an 8-bit APB address.
*/
`ifndef PFT_CFG_SVH
`define PFT_CFG_SVH

`define PFT_ADDR_TIMING 8'h00
`define PFT_ADDR_MODE 8'h04
`define PFT_ADDR_DETECT 8'h08
`define PFT_ADDR_PCUTDIS 8'h0C
`define PFT_ADDR_COMMAND 8'h10
`define PFT_ADDR_STATUS 8'h14
`define PFT_ADDR_FAULT 8'h18

`define PFT_MPDO_LSB 0
`define PFT_OVLD_LSB 2
`define PFT_HI_LSB 8
`define PFT_COOL_LSB 16
`define PFT_TIMING_RESET 4'h0

`define PFT_OVLD_MS_00 60
`define PFT_OVLD_MS_01 30
`define PFT_OVLD_MS_10 120
`define PFT_OVLD_MS_11 240
`define PFT_COOL_MS 1000
`define PFT_LEAK_DIV 16

`define PFT_CLK_NS 10
`define PFT_TICK_NS 1000000
`define PFT_TICK_CYCLES (`PFT_TICK_NS / `PFT_CLK_NS)

`endif

// ===== pft_pkg.sv
/*
  Types shared by the port overload fault timer modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pft_pkg;

  typedef enum logic [1:0] {
    CH_COUNT = 2'h1,
    CH_COOL = 2'h2
  } pft_state_t;

  typedef struct packed {
    logic over;
    logic clear;
    logic abort;
    logic pcutDis;
    logic autoDetect;
  } pft_chin_t;

  typedef struct packed {
    logic timeout;
    logic turnOff;
    logic detect;
    logic cooling;
  } pft_chout_t;

endpackage

`default_nettype wire

// ===== pft_tick.sv
/*
  Free-running time base: one tick per period, and a slower leak tick
  on every sixteenth tick.
  Assumes a single clock with synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pft_cfg.svh"

module pft_tick #(
  parameter int TICK_CYCLES = `PFT_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  output logic tick,
  output logic leakTick
);
  localparam int W = $clog2(TICK_CYCLES);
  localparam int LW = $clog2(`PFT_LEAK_DIV);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic [LW-1:0] leak;
  logic [LW-1:0] next_leak;
  logic next_tick;
  logic next_leakTick;

  if (TICK_CYCLES < 2)
  begin : gBadTick
    $error("pft_tick: TICK_CYCLES must be at least 2");
  end

  always_comb
  begin
    next_count = count + 1'b1;
    next_leak = leak;
    next_tick = 1'b0;
    next_leakTick = 1'b0;
    if (count == W'(TICK_CYCLES - 1))
    begin
      next_count = '0;
      next_tick = 1'b1;
      next_leak = leak + 1'b1;
      next_leakTick = (leak == LW'(`PFT_LEAK_DIV - 1));
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      count <= '0;
      leak <= '0;
      tick <= 1'b0;
      leakTick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      leak <= next_leak;
      tick <= next_tick;
      leakTick <= next_leakTick;
    end
  end

endmodule

`default_nettype wire

// ===== pft_channel.sv
/*
  One channel's overload timer: counts up on ticks while over threshold,
  leaks down otherwise, and runs the cool-down after a turn-off.
  Assumes tick and leakTick are one-cycle pulses from the shared base.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pft_cfg.svh"

module pft_channel #(
  parameter int CW = 10
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic tick,
  input wire logic leakTick,
  input wire logic [CW-1:0] limit,
  input wire pft_pkg::pft_chin_t cin,
  output var pft_pkg::pft_chout_t cout
);
  import pft_pkg::*;

  localparam logic [CW-1:0] COOL_TICKS = CW'(`PFT_COOL_MS);

  pft_state_t state;
  pft_state_t next_state;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  pft_chout_t next_cout;

  if ((1 << CW) <= `PFT_COOL_MS)
  begin : gBadCw
    $error("pft_channel: CW too narrow for the cool-down count");
  end

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_cout = '0;
    case (state)
      CH_COUNT:
      begin
        if (cin.clear)
          next_count = '0;
        else if (tick && cin.over)
        begin
          if (count + 1'b1 >= limit)
          begin
            next_count = '0;
            next_cout.timeout = 1'b1;
            if (!cin.pcutDis)
            begin
              next_cout.turnOff = 1'b1;
              next_state = CH_COOL;
            end
          end
          else
            next_count = count + 1'b1;
        end
        else if (leakTick && !cin.over && count != '0)
          next_count = count - 1'b1;
      end
      CH_COOL:
      begin
        if (cin.abort)
        begin
          next_state = CH_COUNT;
          next_count = '0;
        end
        else if (tick)
        begin
          if (count == COOL_TICKS - 1'b1)
          begin
            next_state = CH_COUNT;
            next_count = '0;
            next_cout.detect = cin.autoDetect;
          end
          else
            next_count = count + 1'b1;
        end
      end
      default:
      begin
        next_state = CH_COUNT;
        next_count = '0;
      end
    endcase
    next_cout.cooling = (next_state == CH_COOL);
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state <= CH_COUNT;
      count <= '0;
      cout <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      cout <= next_cout;
    end
  end

endmodule

`default_nettype wire

// ===== pft_monitor.sv
/*
  Checker of the overload fault timer's port behaviour.
  Assumes it is bound into pft_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pft_cfg.svh"

module pft_monitor #(
  parameter int NCH = 8,
  parameter int CW = 10,
  parameter int TICK_CYCLES = `PFT_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NCH-1:0] overCurrent,
  input wire logic [NCH-1:0] currentLimiting,
  input wire logic [NCH-1:0] powerGoodIn,
  input wire logic [NCH-1:0] dcDisconnect,
  input wire logic [NCH-1:0] currentLimitFault,
  input wire logic [NCH-1:0] startFault,
  input wire logic [NCH-1:0] powerOnRequest,
  input wire logic [NCH-1:0] channelPowerEnable,
  input wire logic [NCH-1:0] channelPowerGood,
  input wire logic [NCH-1:0] detectStart,
  input wire logic [1:0] overloadTimeSelect,
  input wire logic [1:0] disconnectDelaySelect
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic wrDone;
  assign wrDone = psel && penable && pready && pwrite;
  sequence sWait;
    psel && penable && !pready;
  endsequence
  sequence sAnswer;
    pready ##1 !pready;
  endsequence
  a_ready_latency: assert property (sWait |=> sAnswer)
    else $error("pready not one cycle after access");
  a_error_map: assert property (pready && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > 8'h18)) else $error("pslverr wrong");
  a_timing_copy: assert property (
    wrDone && paddr == 8'h00 && pstrb[0] |=>
    {overloadTimeSelect, disconnectDelaySelect} == $past(pwdata[3:0]))
    else $error("timing fields not copied");
  a_fault_off: assert property (currentLimitFault[0] || startFault[0]
    |-> ##[1:3] !channelPowerEnable[0]) else $error("fault kept power");
  a_good_enabled: assert property (
    channelPowerGood[0] ==
    (channelPowerEnable[0] && $past(powerGoodIn[0], 3)))
    else $error("power good does not follow pin");
  a_cmd_off: assert property (wrDone && paddr == 8'h10
    && (pstrb[0] && pwdata[0] || pstrb[1] && pwdata[8])
    |-> ##[1:3] !channelPowerEnable[0]) else $error("command kept power");
  a_detect_off: assert property (detectStart[0]
    |-> !channelPowerEnable[0] ##1 !detectStart[0])
    else $error("detect pulse wrong");
  a_reset_out: assert property (disable iff (1'b0) !resetn
    |=> channelPowerEnable == 0 && detectStart == 0
    && overloadTimeSelect == 2'h0) else $error("outputs live in reset");
endmodule

bind pft_top pft_monitor #(
  .NCH(NCH),
  .CW(CW),
  .TICK_CYCLES(TICK_CYCLES)
) pft_monitor_inst (.*);

`default_nettype wire

// ===== pft_port_model.sv
/*
  Far side of one group of channels: FET and powered load.
  Assumes the bench asks for overload or limiting per channel.
*/
`timescale 1ns/1ns
`default_nettype none

module pft_port_model #(
  parameter int NCH = 8
) (
  input wire logic clock,
  input wire logic [NCH-1:0] enable,
  input wire logic [NCH-1:0] overload,
  input wire logic [NCH-1:0] limitReq,
  output logic [NCH-1:0] overCurrent,
  output logic [NCH-1:0] currentLimiting,
  output logic [NCH-1:0] powerGoodIn
);
  logic [NCH-1:0] ramp1;
  logic [NCH-1:0] ramp2;
  // output rail needs two cycles to settle
  always_ff @(posedge clock)
  begin
    ramp1 <= enable;
    ramp2 <= ramp1 & enable;
  end
  // load draws current only while the FET conducts
  assign overCurrent = overload & enable;
  assign currentLimiting = limitReq & enable;
  assign powerGoodIn = ramp2 & enable;
endmodule

`default_nettype wire

// ===== tb.sv
/*
  Self-checking bench of the overload fault timer.
  Assumes a 20-cycle tick, so one millisecond lasts 20 clocks.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pft_cfg.svh"

module tb;
  localparam int T = 20;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic r;
  } pft_row_t;
  logic clock, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, oc, cl, pg, lf, sf, pon, en, good, det, load, lim, dc;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] ots, dds;
  int errTotal, testsRun, cyc, n;
  int msTab[4] = '{60, 30, 120, 240};
  pft_row_t rows[8] = '{
    '{`PFT_ADDR_TIMING, 32'h0000_000F, 32'h0000_000F, 1'b0},
    '{`PFT_ADDR_MODE, 32'h0000_0101, 32'h0000_0101, 1'b0},
    '{`PFT_ADDR_DETECT, 32'h0000_00FF, 32'h0000_00FF, 1'b0},
    '{`PFT_ADDR_STATUS, 32'h00FF_FFFF, 32'h0000_0000, 1'b0},
    '{`PFT_ADDR_COMMAND, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{8'h1C, 32'h0000_0001, 32'h0000_0000, 1'b1},
    '{`PFT_ADDR_TIMING, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{`PFT_ADDR_MODE, 32'h0000_0000, 32'h0000_0000, 1'b0}};

  pft_top #(.NCH(8), .CW(10), .TICK_CYCLES(T)) pft_top_inst (
    .clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overCurrent(oc), .currentLimiting(cl), .powerGoodIn(pg),
    .dcDisconnect(dc), .currentLimitFault(lf), .startFault(sf),
    .powerOnRequest(pon), .channelPowerEnable(en),
    .channelPowerGood(good), .detectStart(det),
    .overloadTimeSelect(ots), .disconnectDelaySelect(dds));
  pft_port_model #(.NCH(8)) pft_port_model_inst (.clock(clock),
    .enable(en), .overload(load), .limitReq(lim), .overCurrent(oc),
    .currentLimiting(cl), .powerGoodIn(pg));

  task endSim();
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      errTotal++;
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    // pready seen here is its value just before this edge
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // idle cycle between back-to-back transfers
    @(posedge clock);
  endtask
  function automatic logic [31:0] win(int v, int lo, int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction
  task powerUp();
    pon[0] <= 1;
    @(posedge clock);
    pon[0] <= 0;
    repeat (6) @(posedge clock);
    chk("power enable", 1, en[0]);
    chk("power good", 1, good[0]);
  endtask
  task trip(input logic useLim);
    n = 0;
    lim[0] <= useLim;
    load[0] <= !useLim;
    while (en[0] === 1'b1 && n < 6000)
    begin
      @(posedge clock);
      n++;
    end
    lim[0] <= 0;
    load[0] <= 0;
  endtask
  task stop();
    apb(`PFT_ADDR_COMMAND, 1, 32'h0000_0001);
    apb(`PFT_ADDR_FAULT, 1, 32'h0000_00FF);
  endtask

  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errTotal++;
      endSim();
    end
  end

  initial
  begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {lf, sf, pon, load, lim, dc} = '0;
    repeat (20) @(posedge clock);
    resetn <= 1;
    @(posedge clock);
    apb(`PFT_ADDR_TIMING, 0, 0);
    chk("timing reset", 0, rd);
    chk("select reset", 0, {28'h0, ots, dds});
    foreach (rows[i])
    begin
      apb(rows[i].a, 1, rows[i].d);
      apb(rows[i].a, 0, 0);
      chk("read data", rows[i].e, rd);
      chk("slave error", {31'h0, rows[i].r}, {31'h0, er});
    end
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      apb(`PFT_ADDR_TIMING, 1, c << 2);
      powerUp();
      trip(c[0]);
      chk("trip", 1, win(n, (msTab[c] - 1) * T, msTab[c] * T + 10));
      apb(`PFT_ADDR_STATUS, 0, 0);
      chk("cooling", 1, rd[16]);
      apb(`PFT_ADDR_COMMAND, 1, c[0] ? 32'h0000_0100 : 32'h0000_0001);
      apb(`PFT_ADDR_STATUS, 0, 0);
      chk("cool abort", 0, rd[16]);
      stop();
    end
    $display("test timeouts done");
    apb(`PFT_ADDR_TIMING, 1, 0);
    powerUp();
    load[0] <= 1;
    repeat (40 * T) @(posedge clock);
    load[0] <= 0;
    repeat (320 * T) @(posedge clock);
    trip(0);
    chk("leak trip", 1, win(n, 38 * T, 42 * T + 10));
    stop();
    powerUp();
    load[0] <= 1;
    repeat (20 * T) @(posedge clock);
    apb(`PFT_ADDR_TIMING, 1, 32'h0000_0004);
    trip(0);
    chk("restart trip", 1, win(n, 29 * T, 30 * T + 10));
    stop();
    $display("test leak and restart done");
    apb(`PFT_ADDR_PCUTDIS, 1, 1);
    powerUp();
    load[0] <= 1;
    repeat (40 * T) @(posedge clock);
    chk("kept on", 1, en[0]);
    apb(`PFT_ADDR_FAULT, 0, 0);
    chk("fault logged", 1, rd[0]);
    load[0] <= 0;
    apb(`PFT_ADDR_PCUTDIS, 1, 0);
    stop();
    $display("test cut disable done");
    apb(`PFT_ADDR_MODE, 1, 1);
    powerUp();
    trip(1);
    n = 0;
    while (det[0] !== 1'b1 && n < 1000 * T + 100)
    begin
      @(posedge clock);
      n++;
    end
    chk("cool time", 1, win(n, 999 * T - 20, 1000 * T + 20));
    apb(`PFT_ADDR_MODE, 1, 0);
    stop();
    $display("test cool down done");
    for (int k = 0; k < 2; k++)
    begin
      powerUp();
      lf[0] <= k[0];
      sf[0] <= !k[0];
      @(posedge clock);
      {lf, sf} <= '0;
      repeat (4) @(posedge clock);
      chk("fault enable", 0, en[0]);
      chk("fault good", 0, good[0]);
      stop();
    end
    $display("test faults done");
    apb(`PFT_ADDR_TIMING, 1, 0);
    powerUp();
    load[0] <= 1;
    repeat (40 * T) @(posedge clock);
    dc[0] <= 1;
    @(posedge clock);
    dc[0] <= 0;
    load[0] <= 0;
    repeat (2) @(posedge clock);
    chk("disconnect enable", 0, en[0]);
    chk("disconnect good", 0, good[0]);
    powerUp();
    trip(0);
    chk("disconnect clear", 1, win(n, 59 * T, 60 * T + 10));
    stop();
    $display("test disconnect done");
    endSim();
  end
endmodule

`default_nettype wire
